// *** hw/attr_fmt_pkg.sv ***
/*
 * Shared constants for the attribute pixel formatter: register indices,
 * mode-control bit positions, reset value and pixel word layout.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package attr_fmt_pkg;

    // ------------------------------------------------------------------
    // data register indices behind the attribute port
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_MODE   = 5'h10;
    localparam logic [4:0] IDX_BORDER = 5'h11;
    localparam logic [4:0] IDX_PLANE  = 5'h12;
    localparam logic [4:0] IDX_PAN    = 5'h13;
    localparam logic [4:0] IDX_CSEL   = 5'h14;

    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam int         PAL_ENTRIES = 16;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MODE_P54_SEL   = 7;
    localparam int MODE_WIDE      = 6;
    localparam int MODE_PAN_COMPAT = 5;
    localparam int MODE_BLINK     = 3;
    localparam int MODE_LINEGFX   = 2;
    localparam int MODE_MONO      = 1;
    localparam int MODE_GFX       = 0;
    localparam int INDEX_PAL_SRC  = 5;

    localparam logic [7:0] LINEGFX_FIRST = 8'hC0;
    localparam logic [7:0] LINEGFX_LAST  = 8'hDF;
    localparam logic [3:0] PAN_NINE_NONE = 4'h8;

    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------------
    // one fetched dot: ninth-column flag, glyph bit, char code, attribute
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       ninth;
        logic       glyph;
        logic [7:0] code;
        logic [7:0] attr;
    } pix_word_type;

    localparam int WORD_W = $bits(pix_word_type);

    typedef enum logic {
        ACC_INDEX = 1'b0,
        ACC_DATA  = 1'b1
    } access_state_type;

endpackage : attr_fmt_pkg

// *** hw/pix_stream_if.sv ***
/*
 * Valid/ready stream carrying pixel words from the FIFO to the formatter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pix_stream_if #(parameter int WIDTH = 18);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pix_stream_if
`default_nettype wire

// *** hw/word_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    pix_stream_if.src             out
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("word_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;
    logic [AW:0]      nxt_count;

    assign push      = in_valid && in_ready;
    assign pop       = out.valid && out.ready;
    assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign out.valid = (count_ff != '0);
    assign out.data  = mem[rd_ptr_ff];

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            in_ready  <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            count_ff  <= nxt_count;
            // registered so the source sees a flop; full is never overrun
            in_ready  <= (nxt_count < (AW+1)'(DEPTH - 1)) ||
                         (nxt_count == (AW+1)'(DEPTH - 1) && !push);
        end
    end
endmodule : word_fifo
`default_nettype wire

// *** hw/pan_amount.sv ***
/*
 * Turns the effective fine-pan value into a count of dots to drop.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module pan_amount (
    // settings
    input  wire logic [3:0] pan_value,
    input  wire logic       nine_dot,
    input  wire logic       wide_pixel,
    // result
    output logic      [3:0] shift
);
    import attr_fmt_pkg::*;

    always_comb
    begin
        if (wide_pixel)
            shift = {1'b0, pan_value[3:1]};                 // R14
        else if (nine_dot)
            shift = (pan_value < PAN_NINE_NONE) ? pan_value + 4'h1 : 4'h0; // R12
        else
            shift = {1'b0, pan_value[2:0]};                 // R13
    end
endmodule : pan_amount
`default_nettype wire

// *** hw/attribute_pixel_formatter.sv ***
/*
 * Attribute stage: indexed register pair, palette, fine pan and pixel
 * formatting to the 8-bit colour value for the external lookup DAC.
 * Assumes host strobes, timing and pixel words come from logic on the same
 * clock; dot_en marks each dot-clock tick.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: mode bit 7 takes output bits 5:4 from colour-select bits 1:0, else palette.
// R2: mode bit 6 selects 8-bit pixels for 256-colour mode; software keeps it zero otherwise.
// R3: mode bit 5 zeroes pan from line-compare until next vertical sync.
// R4: mode bit 3 makes attribute bit 7 blink enable instead of background intensity.
// R5: mode bit 2 copies eighth dot into ninth for codes C0-DF, else background.
// R6: mode bit 1 picks monochrome (1) or colour (0) emulation.
// R7: mode bit 0 picks text (0) or graphics (1) pixel interpretation.
// R8: border colour is driven between display-enable fall and start of blanking.
// R9: no border in 40-column text or 320-dot graphics, except 256-colour mode.
// R10: plane-enable bits 5:4 route two output bits to status bits 5:4.
// R11: plane-enable bits 3:0 gate each colour plane.
// R12: nine-dot modes: pan 0-7 shifts 1-8 dots, 8 shifts none.
// R13: other modes: pan n shifts n dots, at most seven.
// R14: 256-colour mode: even pan values shift half their value.
// R15: colour-select bits 3:2 drive output bits 7:6 outside 256-colour mode.
// R16: 256-colour mode sends the fetched byte unchanged to the DAC.
// R17: port writes alternate index/data; status read returns to index; data reads don't.
// R18: index bit 5 clear allows palette loads; set lets video reach palette.
// R19: four-bit attribute picks one of sixteen six-bit palette entries.
// R20: outputs are registered and all formatting registers reset to zero.
module attribute_pixel_formatter (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst,
    // host attribute port
    input  wire logic                           attr_wr,
    input  wire logic [7:0]                     attr_wr_data,
    input  wire logic                           attr_rd,
    input  wire logic                           status_rd,
    output logic      [7:0]                     attr_rd_data,
    output logic      [1:0]                     status_pix_bits,
    // fetched pixel words
    input  wire logic                           pix_valid,
    input  wire logic [attr_fmt_pkg::WORD_W-1:0] pix_word,
    output logic                                pix_ready,
    // timing from the crt_timing_unit
    input  wire logic                           dot_en,
    input  wire logic                           display_enable,
    input  wire logic                           blank,
    input  wire logic                           vsync,
    input  wire logic                           line_compare,
    input  wire logic                           blink_phase,
    input  wire logic                           nine_dot_mode,
    input  wire logic                           narrow_mode,
    // to the DAC and sequencer
    output logic      [7:0]                     pixel_out,
    output logic                                mono_emulation,
    output logic                                graphics_mode
);
    import attr_fmt_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    access_state_type acc_ff;
    logic [5:0]       index_ff;
    logic [7:0]       mode_ff;
    logic [7:0]       border_ff;
    logic [7:0]       plane_ff;
    logic [7:0]       pan_ff;
    logic [7:0]       csel_ff;
    logic [5:0]       palette_ff [PAL_ENTRIES];
    logic [7:0]       rd_data_ff;
    logic [1:0]       status_ff;
    logic [7:0]       pixel_ff;
    logic             pan_force_ff;
    logic             vsync_d_ff;
    logic             de_d_ff;
    logic [3:0]       skip_ff;

    logic             data_wr;
    logic [3:0]       eff_pan;
    logic [3:0]       skip_amount;
    logic             vsync_rise;
    logic             de_fall;
    logic             skipping;

    assign data_wr    = attr_wr && (acc_ff == ACC_DATA);
    assign vsync_rise = vsync && !vsync_d_ff;
    assign de_fall    = !display_enable && de_d_ff;
    assign skipping   = !display_enable && (skip_ff != 4'h0);

    assign attr_rd_data    = rd_data_ff;
    assign status_pix_bits = status_ff;
    assign pixel_out       = pixel_ff;
    assign mono_emulation  = mode_ff[MODE_MONO];                    // R6
    assign graphics_mode   = mode_ff[MODE_GFX];

    // ------------------------------------------------------------------
    // pixel FIFO
    // ------------------------------------------------------------------
    pix_stream_if #(.WIDTH(WORD_W)) fifo_out ();

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .in_valid (pix_valid),
        .in_ready (pix_ready),
        .in_data  (pix_word),
        .out      (fifo_out)
    );

    pix_word_type w;
    logic         pop_show;

    assign w        = pix_word_type'(fifo_out.data);
    assign pop_show = dot_en && display_enable && fifo_out.valid;
    // drained at the dot rate while displaying, at full rate while skipping
    assign fifo_out.ready = (dot_en && display_enable) || skipping;

    // ------------------------------------------------------------------
    // index/data flip-flop
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            acc_ff <= ACC_INDEX;
        else if (attr_wr)
            acc_ff <= (acc_ff == ACC_INDEX) ? ACC_DATA : ACC_INDEX;  // R17
        else if (status_rd)
            acc_ff <= ACC_INDEX;                                     // R17
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            index_ff <= REG_RESET[5:0];                              // R20
        else if (attr_wr && acc_ff == ACC_INDEX)
            index_ff <= attr_wr_data[5:0];
    end

    // ------------------------------------------------------------------
    // data register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mode_ff   <= REG_RESET;                                  // R20
            border_ff <= REG_RESET;
            plane_ff  <= REG_RESET;
            pan_ff    <= REG_RESET;
            csel_ff   <= REG_RESET;
        end
        else if (data_wr)
        begin
            unique case (index_ff[4:0])
                IDX_MODE:   mode_ff   <= attr_wr_data & 8'hEF;
                IDX_BORDER: border_ff <= attr_wr_data;
                IDX_PLANE:  plane_ff  <= attr_wr_data & 8'h3F;
                IDX_PAN:    pan_ff    <= attr_wr_data & 8'h0F;
                IDX_CSEL:   csel_ff   <= attr_wr_data & 8'h0F;
                default:    ;
            endcase
        end
    end

    // palette loads only while the video side is cut off from it
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < PAL_ENTRIES; i++)
                palette_ff[i] <= REG_RESET[5:0];                     // R20
        end
        else if (data_wr && !index_ff[4] && !index_ff[INDEX_PAL_SRC])
            palette_ff[index_ff[3:0]] <= attr_wr_data[5:0];          // R18
    end

    // ------------------------------------------------------------------
    // data port read; does not touch the flip-flop
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            rd_data_ff <= REG_RESET;
        else if (attr_rd)
        begin
            if (!index_ff[4])
                rd_data_ff <= {2'b00, palette_ff[index_ff[3:0]]};
            else
            begin
                unique case (index_ff[4:0])
                    IDX_MODE:   rd_data_ff <= mode_ff;
                    IDX_BORDER: rd_data_ff <= border_ff;
                    IDX_PLANE:  rd_data_ff <= plane_ff;
                    IDX_PAN:    rd_data_ff <= pan_ff;
                    IDX_CSEL:   rd_data_ff <= csel_ff;
                    default:    rd_data_ff <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // split-screen pan override
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            vsync_d_ff <= 1'b0;
        else
            vsync_d_ff <= vsync;
    end

    // a match in the same cycle as vsync wins, so the lower pane stays put
    always_ff @(posedge clock)
    begin
        if (rst)
            pan_force_ff <= 1'b0;
        else if (line_compare && mode_ff[MODE_PAN_COMPAT])
            pan_force_ff <= 1'b1;                                    // R3
        else if (vsync_rise)
            pan_force_ff <= 1'b0;                                    // R3
    end

    assign eff_pan = pan_force_ff ? 4'h0 : pan_ff[3:0];              // R3

    pan_amount u_pan (
        .pan_value  (eff_pan),
        .nine_dot   (nine_dot_mode),
        .wide_pixel (mode_ff[MODE_WIDE]),
        .shift      (skip_amount)
    );

    // ------------------------------------------------------------------
    // fine pan: leading dots of the next line are dropped once display enable falls
    // limitation: the source must fetch shift extra dots per line
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            de_d_ff <= 1'b0;
        else
            de_d_ff <= display_enable;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            skip_ff <= 4'h0;
        else if (de_fall)
            skip_ff <= skip_amount;                                  // R12 R13 R14
        else if (skipping && fifo_out.valid)
            skip_ff <= skip_ff - 4'h1;
    end

    // ------------------------------------------------------------------
    // colour formation
    // ------------------------------------------------------------------
    logic       in_linegfx;
    logic       glyph_eff;
    logic       blink_hide;
    logic [3:0] bg_idx;
    logic [3:0] idx;
    logic [5:0] pal;
    logic [7:0] color16;
    logic [7:0] color;
    logic       border_ok;

    always_comb
    begin
        in_linegfx = (w.code >= LINEGFX_FIRST) && (w.code <= LINEGFX_LAST);
        glyph_eff  = w.ninth ? (mode_ff[MODE_LINEGFX] && in_linegfx && w.glyph) // R5
                             : w.glyph;
        blink_hide = mode_ff[MODE_BLINK] && w.attr[7] && blink_phase;   // R4
        bg_idx     = {w.attr[7] && !mode_ff[MODE_BLINK], w.attr[6:4]}; // R4
        if (mode_ff[MODE_GFX])
            idx = w.attr[3:0];                                          // R7
        else
            idx = (glyph_eff && !blink_hide) ? w.attr[3:0] : bg_idx;    // R7
        idx     = idx & plane_ff[3:0];                                  // R11
        pal     = palette_ff[idx];                                      // R19
        color16 = {csel_ff[3:2],                                        // R15
                   mode_ff[MODE_P54_SEL] ? csel_ff[1:0] : pal[5:4],     // R1
                   pal[3:0]};
        color   = mode_ff[MODE_WIDE] ? w.attr : color16;                // R2 R16
        border_ok = !narrow_mode || mode_ff[MODE_WIDE];                 // R9
    end

    // ------------------------------------------------------------------
    // output register, updated once per dot
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            pixel_ff <= REG_RESET;                                   // R20
        else if (dot_en)
        begin
            if (display_enable)
            begin
                if (!fifo_out.valid)
                    pixel_ff <= 8'h00;
                else if (index_ff[INDEX_PAL_SRC])
                    pixel_ff <= color;                               // R18
                else
                    pixel_ff <= border_ff;
            end
            else if (!blank && border_ok)
                pixel_ff <= border_ff;                               // R8
            else
                pixel_ff <= 8'h00;                                   // R9
        end
    end

    // live status bits follow the output pair chosen by plane-enable 5:4
    always_ff @(posedge clock)
    begin
        if (rst)
            status_ff <= 2'b00;
        else
        begin
            unique case (plane_ff[5:4])
                2'b00: status_ff <= {pixel_ff[2], pixel_ff[0]};      // R10
                2'b01: status_ff <= {pixel_ff[5], pixel_ff[4]};
                2'b10: status_ff <= {pixel_ff[3], pixel_ff[1]};
                2'b11: status_ff <= {pixel_ff[7], pixel_ff[6]};
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_shown;
        pop_show && index_ff[INDEX_PAL_SRC];
    endsequence

    sequence s_lc_hit;
        line_compare && mode_ff[MODE_PAN_COMPAT];
    endsequence

    property p_p54_select;
        s_shown and (mode_ff[MODE_P54_SEL] && !mode_ff[MODE_WIDE])
        |=> pixel_ff[5:4] == $past(csel_ff[1:0]);
    endproperty
    a_p54_select: assert property (p_p54_select) else $error("bits 5:4 not from select"); // R1

    property p_wide_direct;
        s_shown and mode_ff[MODE_WIDE] |=> pixel_ff == $past(w.attr);
    endproperty
    a_wide_direct: assert property (p_wide_direct) else $error("256-colour byte altered"); // R16

    property p_bank_high;
        s_shown and !mode_ff[MODE_WIDE] |=> pixel_ff[7:6] == $past(csel_ff[3:2]);
    endproperty
    a_bank_high: assert property (p_bank_high) else $error("bits 7:6 not from bank"); // R15

    property p_border;
        dot_en && !display_enable && !blank && border_ok |=> pixel_ff == $past(border_ff);
    endproperty
    a_border: assert property (p_border) else $error("border colour missing"); // R8

    property p_no_border;
        dot_en && !display_enable && narrow_mode && !mode_ff[MODE_WIDE] |=> pixel_ff == 8'h00;
    endproperty
    a_no_border: assert property (p_no_border) else $error("border in narrow mode"); // R9

    property p_pan_hold;
        s_lc_hit ##1 !vsync_rise[*2] |-> pan_force_ff && eff_pan == 4'h0;
    endproperty
    a_pan_hold: assert property (p_pan_hold) else $error("pan not held at zero"); // R3

    property p_pan_release;
        pan_force_ff && vsync_rise && !line_compare |=> !pan_force_ff;
    endproperty
    a_pan_release: assert property (p_pan_release) else $error("pan not restored"); // R3

    property p_access_toggle;
        attr_wr |=> acc_ff != $past(acc_ff);
    endproperty
    a_access_toggle: assert property (p_access_toggle) else $error("flip-flop stuck"); // R17

    property p_status_clear;
        status_rd && !attr_wr |=> acc_ff == ACC_INDEX;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status read no clear"); // R17

    property p_status_mux;
        plane_ff[5:4] == 2'b01 && $stable(plane_ff) |=> status_ff == $past(pixel_ff[5:4]);
    endproperty
    a_status_mux: assert property (p_status_mux) else $error("status mux wrong"); // R10

endmodule : attribute_pixel_formatter
`default_nettype wire

// *** test/dac_model.sv ***
/* Colour lookup DAC stand-in: latches the address the formatter presents.
   Assumes pixel_out settles one clock after the dot_en cycle. */
`timescale 1ns/1ps
`default_nettype none
module dac_model (
    // dot timing and colour
    input  wire logic       clock,
    input  wire logic       dot_en,
    input  wire logic [7:0] pixel_out,
    // sampled lookup address
    output logic      [7:0] dac_addr
);
    logic dot_ff;
    always_ff @(posedge clock) dot_ff <= dot_en;
    // sample one clock late, the way a real DAC would see the settled value
    always_ff @(posedge clock) if (dot_ff) dac_addr <= pixel_out;
endmodule : dac_model
`default_nettype wire

// *** test/attribute_pixel_formatter_tb_top.sv ***
/* Self-checking bench for the attribute pixel formatter.
   Assumes the package and all design modules are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module attribute_pixel_formatter_tb_top;
    import attr_fmt_pkg::*;
    logic clock = 0, rst = 1, attr_wr = 0, attr_rd = 0, status_rd = 0, pix_valid = 0;
    logic dot_en = 0, display_enable = 0, blank = 0, vsync = 0, line_compare = 0;
    logic blink_phase = 0, nine_dot_mode = 0, narrow_mode = 0;
    logic [7:0] attr_wr_data = 8'h00;
    logic [7:0] attr_rd_data, pixel_out, dac_addr;
    logic [WORD_W-1:0] pix_word = '0;
    logic [9:0] lead = '0;
    logic [1:0] status_pix_bits;
    logic pix_ready, mono_emulation, graphics_mode;
    logic [5:0] pal [16];
    int failures = 0, compares = 0, cycles = 0;

    attribute_pixel_formatter dut (.clock, .rst, .attr_wr, .attr_wr_data, .attr_rd,
        .status_rd, .attr_rd_data, .status_pix_bits, .pix_valid, .pix_word, .pix_ready,
        .dot_en, .display_enable, .blank, .vsync, .line_compare, .blink_phase,
        .nine_dot_mode, .narrow_mode, .pixel_out, .mono_emulation, .graphics_mode);
    dac_model dac (.clock, .dot_en, .pixel_out, .dac_addr);

    always #4 clock = ~clock;
    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // host port and pixel tasks
    // ------------------------------------------------------------
    task step; @(posedge clock); #1; endtask : step
    task tally_and_finish;
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // strobe dropped for one edge so consecutive writes never merge
    task wr(input logic [7:0] d); attr_wr = 1; attr_wr_data = d; step; attr_wr = 0; step;
    endtask : wr
    task point(input logic [7:0] i); status_rd = 1; step; status_rd = 0; wr(i); endtask : point
    task set_reg(input logic [4:0] i, input logic [7:0] v); point({3'b001, i}); wr(v);
    endtask : set_reg
    task rd_chk(input logic [4:0] i, input logic [7:0] e);
        point({3'b001, i});
        attr_rd = 1;
        step;
        attr_rd = 0;
        chk(attr_rd_data, e);
    endtask : rd_chk
    task dot(input logic de, input logic [7:0] e);
        display_enable = de;
        dot_en = 1;
        step;
        dot_en = 0;
        chk(pixel_out, e);
        step;
        chk(dac_addr, e);
    endtask : dot
    task push(input logic [7:0] a);
        chk({7'h00, pix_ready}, 8'h01);
        pix_word = {lead, a};
        pix_valid = 1;
        step;
        pix_valid = 0;
        step;
    endtask : push
    task pix(input logic [7:0] a, input logic [7:0] e);
        push(a);
        dot(1'b1, e);
    endtask : pix

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) step;
        rst = 0;
        step;
        for (int i = 16; i < 21; i++) rd_chk(5'(i), 8'h00);
        set_reg(IDX_MODE, 8'hFF);
        rd_chk(IDX_MODE, 8'hEF);
        chk({6'h00, mono_emulation, graphics_mode}, 8'h03);
        set_reg(IDX_PLANE, 8'hFF);
        rd_chk(IDX_PLANE, 8'h3F);
        set_reg(IDX_PAN, 8'hFF);
        rd_chk(IDX_PAN, 8'h0F);
        set_reg(IDX_CSEL, 8'hFF);
        rd_chk(IDX_CSEL, 8'h0F);
        set_reg(5'h15, 8'hFF);
        rd_chk(5'h15, 8'h00);
        set_reg(IDX_BORDER, 8'hA5);
        rd_chk(IDX_BORDER, 8'hA5);
        attr_rd = 1;
        step;
        attr_rd = 0;
        wr(8'h5A);
        rd_chk(IDX_BORDER, 8'h5A);
        for (int i = 0; i < 16; i++)
        begin
            pal[i] = 6'(i * 5 + 3);
            point(8'(i));
            wr({2'b00, pal[i]});
        end
        point(8'h25);
        wr(8'h3F);
        set_reg(IDX_MODE, 8'h01);
        chk({6'h00, mono_emulation, graphics_mode}, 8'h01);
        set_reg(IDX_PLANE, 8'h0F);
        set_reg(IDX_PAN, 8'h00);
        set_reg(IDX_CSEL, 8'h0C);
        set_reg(IDX_BORDER, 8'hA5);
        pix(8'h05, {2'b11, pal[5]});
        set_reg(IDX_MODE, 8'h81);
        set_reg(IDX_CSEL, 8'h0E);
        pix(8'h05, {4'hE, pal[5][3:0]});
        set_reg(IDX_PLANE, 8'h17);
        pix(8'h0A, {4'hE, pal[2][3:0]});
        chk({6'h00, status_pix_bits}, 8'h02);
        set_reg(IDX_MODE, 8'h41);
        pix(8'h9C, 8'h9C);
        dot(1'b0, 8'hA5);
        narrow_mode = 1;
        dot(1'b0, 8'hA5);
        set_reg(IDX_MODE, 8'h01);
        dot(1'b0, 8'h00);
        narrow_mode = 0;
        set_reg(IDX_PLANE, 8'h0F);
        set_reg(IDX_MODE, 8'h00);
        pix(8'hC5, {2'b11, pal[12]});
        set_reg(IDX_MODE, 8'h08);
        pix(8'hC5, {2'b11, pal[4]});
        lead = 10'h100;
        blink_phase = 1;
        pix(8'hC5, {2'b11, pal[4]});
        blink_phase = 0;
        pix(8'hC5, {2'b11, pal[5]});
        lead = 10'h3C4;
        pix(8'h15, {2'b11, pal[1]});
        set_reg(IDX_MODE, 8'h04);
        pix(8'h15, {2'b11, pal[5]});
        lead = 10'h000;
        set_reg(IDX_PAN, 8'h03);
        set_reg(IDX_MODE, 8'h21);
        line_compare = 1;
        step;
        line_compare = 0;
        dot(1'b0, 8'hA5);
        pix(8'h05, {2'b11, pal[5]});
        vsync = 1;
        step;
        vsync = 0;
        dot(1'b0, 8'hA5);
        for (int i = 1; i < 4; i++) push(8'(i));
        pix(8'h04, {2'b11, pal[4]});
        set_reg(IDX_PAN, 8'h02);
        set_reg(IDX_MODE, 8'h41);
        dot(1'b0, 8'hA5);
        push(8'h77);
        pix(8'h9C, 8'h9C);
        set_reg(IDX_PAN, 8'h00);
        set_reg(IDX_MODE, 8'h01);
        nine_dot_mode = 1;
        dot(1'b0, 8'hA5);
        push(8'h01);
        pix(8'h04, {2'b11, pal[4]});
        nine_dot_mode = 0;
        tally_and_finish();
    end
endmodule : attribute_pixel_formatter_tb_top
`default_nettype wire
